// [hw/program_space_address_unit.sv]
`timescale 1ns/1ps
module program_space_address_unit (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire psau_pkg::access_req_t req,
    output logic req_ready,
    input wire logic [psau_pkg::PAGE_W-1:0] table_page_reg,
    input wire logic [psau_pkg::PAGE_W-1:0] window_page_reg,
    input wire logic [psau_pkg::DATA_W-1:0] core_control_reg,
    input wire logic wreg_we,
    input wire logic [psau_pkg::WREG_IDX_W-1:0] wreg_idx,
    input wire logic [psau_pkg::DATA_W-1:0] wreg_wdata,
    input wire logic prog_rvalid,
    input wire logic [psau_pkg::PROG_W-1:0] prog_rdata,
    input wire logic fetch_advance,
    input wire logic branch_valid,
    input wire logic [psau_pkg::DATA_W-1:0] branch_literal,
    input wire logic irq_disable_valid,
    input wire logic [psau_pkg::DATA_W-1:0] irq_disable_literal,
    output psau_pkg::prog_req_t prog,
    output logic prog_valid,
    output logic [psau_pkg::DATA_W-1:0] src_ea,
    output logic [psau_pkg::DATA_W-1:0] dst_ea,
    output logic [1:0] ea_valid,
    output logic [1:0] remap_hit,
    output logic [psau_pkg::DATA_W-1:0] direct_data,
    output logic direct_valid,
    output logic mode_error,
    output logic remap_write_error,
    output logic rsp_valid,
    output logic [psau_pkg::DATA_W-1:0] rsp_data,
    output logic [psau_pkg::PC_W-1:0] pc,
    output logic [psau_pkg::PROG_W-1:0] fetch_addr,
    output logic [psau_pkg::IRQ_DIS_W-1:0] irq_disable_count,
    output logic irq_disable_load
);
    // ====
    // working registers
    logic [psau_pkg::DATA_W-1:0] wreg [psau_pkg::NUM_WREGS];

    // ====
    // address functions
    function automatic logic [psau_pkg::DATA_W-1:0] calc_ea(
        input psau_pkg::addr_mode_t mode,
        input logic [psau_pkg::DATA_W-1:0] base,
        input logic [psau_pkg::DATA_W-1:0] offset,
        input logic [psau_pkg::DATA_W-1:0] literal
    );
        logic [psau_pkg::DATA_W-1:0] ea;
        ea = base;
        case (mode)
            // RQ1 pointer unchanged
            psau_pkg::mode_indirect: ea = base;
            // RQ2 use before step
            psau_pkg::mode_post: ea = base;
            // RQ3 updated value used
            psau_pkg::mode_pre: ea = base + literal;
            // RQ4 base plus offset
            psau_pkg::mode_indexed: ea = base + offset;
            // RQ5 base plus literal
            psau_pkg::mode_literal: ea = base + literal;
            default: ea = base;
        endcase
        return ea;
    endfunction

    function automatic logic is_table(input psau_pkg::op_kind_t op);
        return op != psau_pkg::op_data;
    endfunction

    function automatic logic is_table_write(input psau_pkg::op_kind_t op);
        return op == psau_pkg::op_table_write_low || op == psau_pkg::op_table_write_high;
    endfunction

    // ====
    // per-operand address generation
    logic read_pending;
    logic take;
    logic illegal;
    logic window_on;
    logic [psau_pkg::DATA_W-1:0] step;
    logic [psau_pkg::DATA_W-1:0] offset_val;
    logic [psau_pkg::DATA_W-1:0] op_ea [2];
    logic [psau_pkg::DATA_W-1:0] op_mod_val [2];
    logic [1:0] op_mod_we;
    logic [1:0] op_has_ea;
    logic [1:0] op_remap;
    psau_pkg::operand_t opnd [2];

    assign req_ready = !read_pending;
    assign take = req_valid && req_ready;
    // RQ7 one shared offset field
    assign offset_val = wreg[req.offset_idx];
    assign opnd[0] = req.src;
    assign opnd[1] = req.dst;
    assign step = req.byte_mode ? psau_pkg::BYTE_STEP : psau_pkg::WORD_STEP;
    // RQ21 enable bit gates window
    assign window_on = core_control_reg[psau_pkg::WINDOW_ENABLE_BIT];

    // RQ6 indexed reserved for moves
    always_comb begin
        illegal = 1'b0;
        if (!req.is_move) begin
            illegal = (req.src.mode == psau_pkg::mode_indexed)
                   || (req.dst.mode == psau_pkg::mode_indexed);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_operand
            logic [psau_pkg::DATA_W-1:0] base;
            assign base = wreg[opnd[gi].base_idx];
            // RQ7 each operand its own mode
            assign op_ea[gi] = calc_ea(opnd[gi].mode, base, offset_val, opnd[gi].literal);
            // RQ24 direct makes no address
            assign op_has_ea[gi] = opnd[gi].mode != psau_pkg::mode_direct;
            assign op_mod_we[gi] = (opnd[gi].mode == psau_pkg::mode_post)
                                || (opnd[gi].mode == psau_pkg::mode_pre);
            // RQ2 RQ3 pointer writeback
            assign op_mod_val[gi] = (opnd[gi].mode == psau_pkg::mode_pre) ? op_ea[gi] :
                                    opnd[gi].post_dec ? base - step : base + step;
            // RQ21 RQ22 window only outside table ops
            assign op_remap[gi] = window_on && op_has_ea[gi]
                               && op_ea[gi][psau_pkg::REMAP_SEL_BIT] && !is_table(req.op);
        end
    endgenerate

    // ====
    // working register update
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < psau_pkg::NUM_WREGS; i++) begin
                wreg[i] <= 16'h0000;
            end
        end else begin
            if (wreg_we) begin
                wreg[wreg_idx] <= wreg_wdata;
            end
            // destination wins a shared pointer
            if (take && !illegal) begin
                for (int k = 0; k < 2; k++) begin
                    if (op_mod_we[k]) begin
                        wreg[opnd[k].base_idx] <= op_mod_val[k];
                    end
                end
            end
        end
    end

    // ====
    // program address formation
    logic [psau_pkg::DATA_W-1:0] tbl_ea;
    logic [psau_pkg::PROG_W-1:0] table_addr;
    logic [psau_pkg::PROG_W-1:0] window_addr;
    logic [psau_pkg::DATA_W-1:0] map_rd;
    logic [psau_pkg::PROG_W-1:0] map_wword;
    logic [2:0] map_wbe;
    psau_pkg::op_kind_t pend_op;
    logic pend_byte;
    logic pend_sel;

    // reads via source, writes via destination
    assign tbl_ea = is_table_write(req.op) ? op_ea[1] : op_ea[0];
    // RQ9 page above address
    assign table_addr = {table_page_reg, tbl_ea};
    // RQ11 RQ12 window page above low 15 bits
    assign window_addr = {1'b0, window_page_reg, op_ea[0][psau_pkg::REMAP_SEL_BIT-1:0]};

    program_lane_mapper write_lanes (
        .op(req.op),
        .byte_mode(req.byte_mode),
        .byte_sel(tbl_ea[0]),
        .prog_rdata(prog_rdata),
        .wdata(req.wdata),
        .rd_data(),
        .wr_word(map_wword),
        .wr_be(map_wbe)
    );

    program_lane_mapper read_lanes (
        .op(pend_op),
        .byte_mode(pend_byte),
        .byte_sel(pend_sel),
        .prog_rdata(prog_rdata),
        .wdata(req.wdata),
        .rd_data(map_rd),
        .wr_word(),
        .wr_be()
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            prog <= '0;
            prog_valid <= 1'b0;
            remap_write_error <= 1'b0;
        end else begin
            prog_valid <= 1'b0;
            remap_write_error <= 1'b0;
            prog.read <= 1'b0;
            prog.write <= 1'b0;
            if (take && !illegal) begin
                if (is_table(req.op)) begin
                    prog.addr <= table_addr;
                    // RQ10 page top bit picks space
                    prog.config_space <= table_page_reg[psau_pkg::TABLE_CFG_BIT];
                    prog.remap <= 1'b0;
                    prog.read <= !is_table_write(req.op);
                    prog.write <= is_table_write(req.op);
                    prog.wdata <= map_wword;
                    prog.wbe <= map_wbe;
                    prog_valid <= 1'b1;
                end else if (op_remap[0]) begin
                    prog.addr <= window_addr;
                    // RQ11 window reaches user space only
                    prog.config_space <= 1'b0;
                    prog.remap <= 1'b1;
                    prog.read <= 1'b1;
                    prog.wbe <= 3'h0;
                    prog_valid <= 1'b1;
                end
                // RQ20 window refuses writes
                if (op_remap[1]) begin
                    remap_write_error <= 1'b1;
                end
            end
        end
    end

    // ====
    // read response
    always_ff @(posedge core_clk) begin
        if (reset) begin
            read_pending <= 1'b0;
            pend_op <= psau_pkg::op_data;
            pend_byte <= 1'b0;
            pend_sel <= 1'b0;
        end else begin
            if (take && !illegal && !is_table_write(req.op)
                && (is_table(req.op) || op_remap[0])) begin
                read_pending <= 1'b1;
                pend_op <= req.op;
                // RQ19 byte or word per request
                pend_byte <= req.byte_mode;
                pend_sel <= tbl_ea[0];
            end else if (prog_rvalid) begin
                read_pending <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
        end else begin
            rsp_valid <= read_pending && prog_rvalid;
            // RQ14 RQ16 RQ20 lane mapping
            if (read_pending && prog_rvalid) begin
                rsp_data <= map_rd;
            end
        end
    end

    // ====
    // data-space effective addresses
    always_ff @(posedge core_clk) begin
        if (reset) begin
            src_ea <= 16'h0000;
            dst_ea <= 16'h0000;
            ea_valid <= 2'h0;
            remap_hit <= 2'h0;
            direct_data <= 16'h0000;
            direct_valid <= 1'b0;
            mode_error <= 1'b0;
        end else begin
            ea_valid <= 2'h0;
            remap_hit <= 2'h0;
            direct_valid <= 1'b0;
            mode_error <= take && illegal;
            if (take && !illegal) begin
                src_ea <= op_ea[0];
                dst_ea <= op_ea[1];
                ea_valid <= op_has_ea & {!op_remap[1], !op_remap[0]};
                remap_hit <= op_remap;
                // RQ24 register itself is the operand
                if (!op_has_ea[0]) begin
                    direct_data <= wreg[req.src.base_idx];
                    direct_valid <= 1'b1;
                end
            end
        end
    end

    // ====
    // program counter and fetch
    logic [psau_pkg::PC_W-1:0] branch_offset;

    // RQ8 signed word offset from the literal
    assign branch_offset = psau_pkg::PC_W'({{(psau_pkg::PC_W - psau_pkg::DATA_W - 1)
                                            {branch_literal[psau_pkg::DATA_W-1]}},
                                           branch_literal, 1'b0});

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pc <= psau_pkg::PC_RESET;
        end else if (branch_valid) begin
            pc <= pc + branch_offset;
        // RQ13 two per program word
        end else if (fetch_advance) begin
            pc <= pc + psau_pkg::PC_STEP;
        end
    end

    // RQ23 fetch address framing
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fetch_addr <= '0;
        end else begin
            fetch_addr <= {1'b0, pc[psau_pkg::PC_W-1:1], 1'b0};
        end
    end

    // ====
    // interrupt-disable literal
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_disable_count <= '0;
            irq_disable_load <= 1'b0;
        end else begin
            irq_disable_load <= irq_disable_valid;
            // RQ8 unsigned 14-bit field
            if (irq_disable_valid) begin
                irq_disable_count <= irq_disable_literal[psau_pkg::IRQ_DIS_W-1:0];
            end
        end
    end
endmodule

// [hw/psau_pkg.sv]
// Functional notes
// RQ1: indirect uses pointer as address
// RQ2: post-modify: use, then step
// RQ3: pre-modify: step, then use
// RQ4: indexed: base plus offset
// RQ5: literal: base plus literal
// RQ6: indexed mode only for moves
// RQ7: moves: own modes, shared offset
// RQ8: branch 16 signed, disable 14 bits
// RQ9: table: page above address
// RQ10: page bit 7 selects config
// RQ11: window: page above 15 bits
// RQ12: window: bit 23 zero, bit 15 dropped
// RQ13: pc steps two per word
// RQ14: read low word: bits 15..0
// RQ15: read low byte: select picks byte
// RQ16: read high word: bits 23..16
// RQ17: phantom byte reads zero
// RQ18: upper byte only via high ops
// RQ19: table ops byte or word
// RQ20: window read-only, low word
// RQ21: window needs enable and bit 15
// RQ22: no window during table ops
// RQ23: fetch: zero, pc[22:1], zero
// RQ24: direct: register, no address
package psau_pkg;
    localparam int DATA_W = 16;
    localparam int PROG_W = 24;
    localparam int PC_W = 23;
    localparam int NUM_WREGS = 16;
    localparam int WREG_IDX_W = 4;
    localparam int PAGE_W = 8;
    localparam int REMAP_SEL_BIT = 15;
    localparam int TABLE_CFG_BIT = 7;
    localparam int WINDOW_ENABLE_BIT = 2;
    localparam int IRQ_DIS_W = 14;
    localparam logic [PC_W-1:0] PC_RESET = 23'h000000;
    localparam logic [PC_W-1:0] PC_STEP = 23'h000002;
    localparam logic [DATA_W-1:0] BYTE_STEP = 16'h0001;
    localparam logic [DATA_W-1:0] WORD_STEP = 16'h0002;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    typedef enum logic [5:0] {
        mode_direct = 6'h01,
        mode_indirect = 6'h02,
        mode_post = 6'h04,
        mode_pre = 6'h08,
        mode_indexed = 6'h10,
        mode_literal = 6'h20
    } addr_mode_t;

    typedef enum logic [4:0] {
        op_data = 5'h01,
        op_table_read_low = 5'h02,
        op_table_read_high = 5'h04,
        op_table_write_low = 5'h08,
        op_table_write_high = 5'h10
    } op_kind_t;

    typedef struct packed {
        addr_mode_t mode;
        logic [WREG_IDX_W-1:0] base_idx;
        logic post_dec;
        logic [DATA_W-1:0] literal;
    } operand_t;

    typedef struct packed {
        op_kind_t op;
        logic is_move;
        logic byte_mode;
        operand_t src;
        operand_t dst;
        logic [WREG_IDX_W-1:0] offset_idx;
        logic [DATA_W-1:0] wdata;
    } access_req_t;

    typedef struct packed {
        logic [PROG_W-1:0] addr;
        logic read;
        logic write;
        logic config_space;
        logic remap;
        logic [PROG_W-1:0] wdata;
        logic [2:0] wbe;
    } prog_req_t;
endpackage

// [hw/program_lane_mapper.sv]
`timescale 1ns/1ps
module program_lane_mapper (
    input wire psau_pkg::op_kind_t op,
    input wire logic byte_mode,
    input wire logic byte_sel,
    input wire logic [psau_pkg::PROG_W-1:0] prog_rdata,
    input wire logic [psau_pkg::DATA_W-1:0] wdata,
    output logic [psau_pkg::DATA_W-1:0] rd_data,
    output logic [psau_pkg::PROG_W-1:0] wr_word,
    output logic [2:0] wr_be
);
    // ====
    // read lanes
    always_comb begin
        rd_data = '0;
        case (op)
            psau_pkg::op_table_read_high: begin
                // RQ16 upper byte zero
                if (!byte_mode) begin
                    rd_data = {psau_pkg::ZERO_BYTE, prog_rdata[23:16]};
                // RQ17 phantom reads zero
                end else if (!byte_sel) begin
                    rd_data = {psau_pkg::ZERO_BYTE, prog_rdata[23:16]};
                end
            end
            default: begin
                // RQ14 RQ20 low word
                if (!byte_mode || op == psau_pkg::op_data) begin
                    rd_data = prog_rdata[15:0];
                // RQ15 byte select
                end else if (byte_sel) begin
                    rd_data = {psau_pkg::ZERO_BYTE, prog_rdata[15:8]};
                end else begin
                    rd_data = {psau_pkg::ZERO_BYTE, prog_rdata[7:0]};
                end
            end
        endcase
    end

    // ====
    // write lanes
    always_comb begin
        wr_word = {wdata[7:0], wdata};
        wr_be = 3'h0;
        case (op)
            // RQ18 upper byte only here
            psau_pkg::op_table_write_high: begin
                wr_be = (byte_mode && byte_sel) ? 3'h0 : 3'h4;
            end
            // RQ19 byte or word
            psau_pkg::op_table_write_low: begin
                if (!byte_mode) begin
                    wr_be = 3'h3;
                end else if (byte_sel) begin
                    wr_word = {wdata[7:0], wdata[7:0], wdata[7:0]};
                    wr_be = 3'h2;
                end else begin
                    wr_be = 3'h1;
                end
            end
            default: begin
                wr_be = 3'h0;
            end
        endcase
    end
endmodule

// [verification/psau_props.sv]
`timescale 1ns/1ps
module psau_props (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic req_ready,
    input wire logic [psau_pkg::PAGE_W-1:0] table_page_reg,
    input wire logic [psau_pkg::PAGE_W-1:0] window_page_reg,
    input wire logic [psau_pkg::DATA_W-1:0] core_control_reg,
    input wire logic prog_rvalid,
    input wire logic fetch_advance,
    input wire logic branch_valid,
    input wire logic [psau_pkg::DATA_W-1:0] branch_literal,
    input wire logic irq_disable_valid,
    input wire logic [psau_pkg::DATA_W-1:0] irq_disable_literal,
    input wire psau_pkg::prog_req_t prog,
    input wire logic prog_valid,
    input wire logic [psau_pkg::DATA_W-1:0] src_ea,
    input wire logic [1:0] ea_valid,
    input wire logic mode_error,
    input wire logic rsp_valid,
    input wire logic [psau_pkg::PC_W-1:0] pc,
    input wire logic [psau_pkg::PROG_W-1:0] fetch_addr,
    input wire logic [psau_pkg::IRQ_DIS_W-1:0] irq_disable_count,
    input wire logic irq_disable_load
);
    // ====
    // last-cycle copies
    logic [22:0] br_off;
    logic [13:0] irq_lit;
    logic [22:0] pc_q;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    always_ff @(posedge core_clk) begin
        br_off <= {{6{branch_literal[15]}}, branch_literal, 1'b0};
        irq_lit <= irq_disable_literal[13:0];
        pc_q <= pc;
    end
    property p_rsp;
        prog_rvalid && !req_ready |=> rsp_valid;
    endproperty
    a_rsp: assert property (p_rsp) else $error("no answer");
    property p_busy;
        prog_valid && prog.read |-> !req_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
    property p_table;
        prog_valid && !prog.remap |-> prog.addr[23:16] == $past(table_page_reg)
            && prog.config_space == prog.addr[23];
    endproperty
    a_table: assert property (p_table) else $error("table page not on top");
    property p_window;
        prog_valid && prog.remap |-> prog.addr == {1'b0, $past(window_page_reg), src_ea[14:0]}
            && src_ea[15] && prog.read && !prog.write
            && ($past(core_control_reg) & 16'h0004) != 16'h0000;
    endproperty
    a_window: assert property (p_window) else $error("bad window access");
    property p_mode;
        mode_error |-> !prog_valid && ea_valid == 2'h0;
    endproperty
    a_mode: assert property (p_mode) else $error("dropped request went out");
    property p_fetch;
        fetch_addr == {1'b0, pc_q[22:1], 1'b0};
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch address wrong");
    property p_step;
        fetch_advance && !branch_valid |=> pc == $past(pc) + psau_pkg::PC_STEP;
    endproperty
    a_step: assert property (p_step) else $error("bad pc step");
    property p_branch;
        branch_valid |=> pc == $past(pc) + br_off;
    endproperty
    a_branch: assert property (p_branch) else $error("bad branch");
    property p_irq;
        irq_disable_valid |=> irq_disable_load && irq_disable_count == irq_lit;
    endproperty
    a_irq: assert property (p_irq) else $error("disable count wrong");
    c_rsp: cover property (rsp_valid);
    c_win: cover property (prog_valid && prog.remap);
    c_err: cover property (mode_error);
endmodule
bind program_space_address_unit psau_props u_props (.*);

// [verification/program_memory_model.sv]
`timescale 1ns/1ps
module program_memory_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire psau_pkg::prog_req_t prog,
    input wire logic prog_valid,
    input wire logic [3:0] delay,
    output logic prog_rvalid,
    output logic [psau_pkg::PROG_W-1:0] prog_rdata
);
    // ====
    // data is address xor a pattern; idle data toggles
    logic busy;
    logic [3:0] cnt;
    logic [23:0] pend;
    always @(posedge core_clk) begin
        prog_rvalid <= 1'b0;
        prog_rdata <= ~prog_rdata;
        if (reset) begin
            busy <= 1'b0;
            prog_rdata <= 24'hFFFFFF;
        end else if (prog_valid && prog.read) begin
            busy <= 1'b1;
            cnt <= delay;
            pend <= prog.addr ^ 24'h5A3C96;
        end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            prog_rvalid <= 1'b1;
            prog_rdata <= pend;
        end else if (busy) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    logic wreg_we = 1'b0;
    logic fetch_advance = 1'b0;
    logic branch_valid = 1'b0;
    logic irq_disable_valid = 1'b0;
    logic [3:0] wreg_idx = 4'h0;
    logic [3:0] dly = 4'h0, s_ev;
    logic [7:0] table_page_reg = 8'h00;
    logic [7:0] window_page_reg = 8'h00;
    logic [15:0] core_control_reg = 16'h0000;
    logic [15:0] wreg_wdata = 16'h0000;
    logic [15:0] branch_literal = 16'h0000;
    logic [15:0] irq_disable_literal = 16'h0000;
    psau_pkg::access_req_t req = '0;
    psau_pkg::access_req_t r;
    psau_pkg::prog_req_t prog;
    logic req_ready, prog_valid, prog_rvalid, direct_valid, mode_error;
    logic remap_write_error, rsp_valid, irq_disable_load, s_pv, s_me, s_we, s_dv;
    logic [1:0] ea_valid, remap_hit;
    logic [15:0] src_ea, dst_ea, direct_data, rsp_data, s_rd;
    logic [22:0] pc;
    logic [23:0] prog_rdata, fetch_addr;
    logic [13:0] irq_disable_count;
    int errors = 0;
    int check_count = 0;
    always #50 core_clk = ~core_clk;
    program_space_address_unit uut (.*);
    program_memory_model flash (.core_clk, .reset, .prog, .prog_valid, .delay(dly),
        .prog_rvalid, .prog_rdata);
    // ====
    // shared tasks
    task wrap_up;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] i, input logic [15:0] v);
        @(posedge core_clk);
        wreg_we <= 1'b1;
        wreg_idx <= i;
        wreg_wdata <= v;
        @(posedge core_clk);
        wreg_we <= 1'b0;
    endtask
    task go;
        int k;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= r;
        @(posedge core_clk);
        req_valid <= 1'b0;
        #1;
        {s_ev, s_pv, s_me, s_we, s_dv} = {remap_hit, ea_valid, prog_valid, mode_error,
            remap_write_error,
            direct_valid};
        if (s_pv === 1'b1 && prog.read === 1'b1) begin
            k = 0;
            while (rsp_valid !== 1'b1 && k < 20) begin
                @(posedge core_clk);
                #1;
                k++;
            end
            if (k == 20) begin
                errors++;
                $display("mismatch at %0t: no read answer", $time);
                wrap_up;
            end
            s_rd = rsp_data;
        end
    endtask
    task op(input psau_pkg::op_kind_t k, input psau_pkg::addr_mode_t m,
            input logic [3:0] b, input logic [15:0] l, input logic bm);
        r = '0;
        r.op = k;
        r.byte_mode = bm;
        r.wdata = 16'h1234;
        r.src.mode = m;
        r.src.base_idx = b;
        r.src.literal = l;
        r.dst.mode = psau_pkg::mode_direct;
        if (k == psau_pkg::op_table_write_low || k == psau_pkg::op_table_write_high) begin
            r.dst = r.src;
            r.src.mode = psau_pkg::mode_direct;
        end
        go;
    endtask
    // ====
    // scenarios
    task s_modes;
        wr(4'h1, 16'h1000);
        wr(4'h2, 16'h0010);
        op(psau_pkg::op_data, psau_pkg::mode_indirect, 4'h1, 16'h0000, 1'b0);
        chk(src_ea, 24'h1000);
        chk(s_ev[0], 24'h1);
        op(psau_pkg::op_data, psau_pkg::mode_post, 4'h1, 16'h0000, 1'b0);
        chk(src_ea, 24'h1000);
        op(psau_pkg::op_data, psau_pkg::mode_indirect, 4'h1, 16'h0000, 1'b0);
        chk(src_ea, 24'h1002);
        op(psau_pkg::op_data, psau_pkg::mode_pre, 4'h1, 16'hFFFC, 1'b0);
        chk(src_ea, 24'h0FFE);
        op(psau_pkg::op_data, psau_pkg::mode_literal, 4'h1, 16'h0020, 1'b0);
        chk(src_ea, 24'h101E);
        op(psau_pkg::op_data, psau_pkg::mode_direct, 4'h2, 16'h0000, 1'b0);
        chk({s_dv, direct_data}, 24'h10010);
        chk(s_ev, 24'h0);
    endtask
    task s_move;
        r = '0;
        r.op = psau_pkg::op_data;
        r.is_move = 1'b1;
        r.offset_idx = 4'h2;
        r.src.mode = psau_pkg::mode_indexed;
        r.src.base_idx = 4'h1;
        r.dst.mode = psau_pkg::mode_literal;
        r.dst.base_idx = 4'h2;
        r.dst.literal = 16'h0004;
        go;
        chk(src_ea, 24'h100E);
        chk({s_ev, dst_ea}, 24'h30014);
        op(psau_pkg::op_data, psau_pkg::mode_indexed, 4'h1, 16'h0000, 1'b0);
        chk({s_me, s_ev}, 24'h10);
    endtask
    task s_table;
        logic [15:0] ea;
        logic [23:0] a, p, e;
        core_control_reg <= 16'h0004;
        wr(4'h3, 16'h8006);
        wr(4'h4, 16'h8007);
        for (int i = 0; i < 6; i++) begin
            table_page_reg <= (i % 2 == 1) ? 8'h85 : 8'h05;
            dly <= 4'(i);
            ea = (i % 3 == 2) ? 16'h8007 : 16'h8006;
            op((i < 3) ? psau_pkg::op_table_read_low : psau_pkg::op_table_read_high,
                psau_pkg::mode_indirect, (i % 3 == 2) ? 4'h4 : 4'h3, 16'h0000, i % 3 != 0);
            a = {table_page_reg, ea};
            p = a ^ 24'h5A3C96;
            case (i)
                0: e = {8'h00, p[15:0]};
                1: e = {16'h0000, p[7:0]};
                2: e = {16'h0000, p[15:8]};
                3, 4: e = {16'h0000, p[23:16]};
                default: e = 24'h0;
            endcase
            chk(prog.addr, a);
            chk(prog.config_space, 24'(i % 2));
            chk(prog.remap, 24'h0);
            chk(s_rd, e);
        end
    endtask
    task s_write;
        op(psau_pkg::op_table_write_low, psau_pkg::mode_indirect, 4'h3, 16'h0000, 1'b0);
        chk({prog.write, prog.wbe, prog.wdata[15:0]}, 24'hB1234);
        op(psau_pkg::op_table_write_high, psau_pkg::mode_indirect, 4'h3, 16'h0000, 1'b0);
        chk(prog.wbe, 24'h4);
        op(psau_pkg::op_table_write_high, psau_pkg::mode_indirect, 4'h4, 16'h0000, 1'b1);
        chk(prog.wbe, 24'h0);
    endtask
    task s_window;
        window_page_reg <= 8'hA7;
        wr(4'h5, 16'h8123);
        op(psau_pkg::op_data, psau_pkg::mode_indirect, 4'h5, 16'h0000, 1'b0);
        chk({s_ev, prog.remap, prog.addr}, 32'h09538123);
        chk(s_rd, 16'h8123 ^ 16'h3C96);
        r = '0;
        r.op = psau_pkg::op_data;
        r.src.mode = psau_pkg::mode_direct;
        r.dst.mode = psau_pkg::mode_indirect;
        r.dst.base_idx = 4'h5;
        go;
        chk({s_ev, s_we, s_pv}, 24'h22);
        core_control_reg <= 16'h0000;
        op(psau_pkg::op_data, psau_pkg::mode_indirect, 4'h5, 16'h0000, 1'b0);
        chk({s_pv, s_ev[0]}, 24'h1);
    endtask
    task s_pc;
        @(posedge core_clk);
        fetch_advance <= 1'b1;
        repeat (3) @(posedge core_clk);
        fetch_advance <= 1'b0;
        #1;
        chk(pc, 24'h6);
        @(posedge core_clk);
        branch_valid <= 1'b1;
        branch_literal <= 16'hFFFF;
        @(posedge core_clk);
        branch_valid <= 1'b0;
        #1;
        chk(pc, 24'h4);
        @(posedge core_clk);
        irq_disable_valid <= 1'b1;
        irq_disable_literal <= 16'hFABC;
        @(posedge core_clk);
        irq_disable_valid <= 1'b0;
        #1;
        chk(fetch_addr, 24'h4);
        chk({irq_disable_load, irq_disable_count}, 24'h7ABC);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        s_modes;
        s_move;
        s_table;
        s_write;
        s_window;
        s_pc;
        wrap_up;
    end
endmodule
